// *** rtl/ipc_consts.svh ***
// Register offsets, field positions, reset values and sizes of the interrupt priority controller.
`ifndef IPC_CONSTS_SVH
`define IPC_CONSTS_SVH
`define IPC_NUM_SRC         32
`define IPC_NUM_FLAG_REGS   6
`define IPC_ADDR_FLAG0      8'h00
`define IPC_ADDR_FLAG5      8'h05
`define IPC_ADDR_ENABLE0    8'h08
`define IPC_ADDR_ENABLE1    8'h09
`define IPC_ADDR_PRIO0      8'h10
`define IPC_ADDR_PRIO7      8'h17
`define IPC_ADDR_CTRL1      8'h20
`define IPC_ADDR_CTRL2      8'h21
`define IPC_ADDR_PENDING    8'h22
`define IPC_ADDR_ALU_STATUS 8'h23
`define IPC_ADDR_CORE_CTRL  8'h24
`define IPC_ADDR_EV_STATUS  8'h28
`define IPC_ADDR_EV_CLEAR   8'h29
`define IPC_ADDR_EV_ENABLE  8'h2A
`define IPC_ENABLE1_MASK    16'hF85F
`define IPC_RESET_VECTOR    24'h00_0000
`define IPC_LEVEL_LSB       5
`define IPC_LEVEL_TOP_BIT   3
`define IPC_NEST_DIS_BIT    15
`define IPC_ALT_TABLE_BIT   15
`define IPC_WAKE_FLAG_IDX   80
`define IPC_NUM_EVENTS      3
`endif

// *** rtl/ipc_pkg.sv ***
// Types of the interrupt priority controller.
package ipc_pkg;
    typedef enum logic [1:0] {PWR_RUN, PWR_ENTER, PWR_IDLE, PWR_SLEEP} ipc_pwr_t;
    typedef struct packed {
        logic [5:0][15:0] flag;
        logic [5:0][15:0] enable;
        logic [7:0][15:0] prio;
        logic [15:0]      ctrl1;
        logic [15:0]      ctrl2;
        logic [6:0]       vector_number_field;
        logic [3:0]       pending_level_field;
        logic [2:0]       cpu_level_low;
        logic             cpu_level_top_bit;
        logic [2:0]       ev_status;
        logic [2:0]       ev_enable;
        ipc_pwr_t         pwr;
        logic             deferred;
        logic             wake;
        logic             cpu_irq;
        logic             irq;
        logic             use_alt_table;
        logic [23:0]      pc_reset;
        logic [15:0]      rdata;
    } ipc_state_t;
endpackage

// *** rtl/ipc_controller.sv ***
// Prioritising interrupt controller with register port, idle wake and power-save deferral.
//
// The register addresses and the plain strobed port were left to the implementer.
`include "ipc_consts.svh"
module ipc_controller (
    input  wire logic                      i_ref_clk,
    input  wire logic                      i_rstn,
    input  wire logic                      i_clk_en,
    input  wire logic [`IPC_NUM_SRC-1:0]   i_src_req,
    input  wire logic                      i_low_power_wake_detector,
    input  wire logic                      i_power_save_instruction,
    input  wire logic                      i_power_save_sleep,
    input  wire logic                      i_trap_set,
    input  wire logic                      i_cpu_level_top_set,
    input  wire logic                      i_cpu_level_top_clr,
    input  wire logic                      i_irq_ack,
    input  wire logic [7:0]                i_addr,
    input  wire logic [15:0]               i_wdata,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    output logic      [15:0]               o_rdata,
    output logic                           o_cpu_irq,
    output logic      [6:0]                o_vector_number,
    output logic      [3:0]                o_pending_level,
    output logic                           o_use_alt_table,
    output logic                           o_nesting_disable,
    output logic                           o_wake,
    output logic      [23:0]               o_reset_pc,
    output logic                           o_irq
);
    ipc_pkg::ipc_state_t st_ff;
    ipc_pkg::ipc_state_t nxt_st;

    logic [`IPC_NUM_SRC-1:0] src_live;
    logic [`IPC_NUM_SRC-1:0][2:0] src_prio;

    // Each source maps to the same bit position in flag and enable registers; each priority register holds four sources in 4-bit slots.
    generate
        for (genvar g = 0; g < `IPC_NUM_SRC; g++)
        begin : g_src
            assign src_live[g] = st_ff.flag[g/16][g%16] & st_ff.enable[g/16][g%16];
            assign src_prio[g] = st_ff.prio[g/4][(g%4)*4 +: 3];
        end
    endgenerate

    logic [3:0]  cpu_level;
    logic [2:0]  best_prio;
    logic [6:0]  best_vec;
    logic        best_any;
    logic        any_enabled;
    logic [15:0] rd_mux;
    logic [15:0] clr_mask;
    logic [2:0]  ev_set;

    assign cpu_level = {st_ff.cpu_level_top_bit, st_ff.cpu_level_low};

    always_comb
    begin
        best_prio   = 3'h0;
        best_vec    = 7'h00;
        best_any    = 1'b0;
        any_enabled = |src_live;
        // Scanning downward with >= leaves the lowest vector among equal levels.
        for (int i = `IPC_NUM_SRC - 1; i >= 0; i--)
        begin
            if (src_live[i] && src_prio[i] != 3'h0 && (!best_any || src_prio[i] >= best_prio))
            begin
                best_prio = src_prio[i];
                best_vec  = 7'(i);
                best_any  = 1'b1;
            end
        end
    end

    always_comb
    begin
        rd_mux = 16'h0000;
        if (i_addr >= `IPC_ADDR_FLAG0 && i_addr <= `IPC_ADDR_FLAG5)
        begin
            rd_mux = (i_addr == `IPC_ADDR_FLAG5) ? 16'h0000 : st_ff.flag[i_addr[2:0]];
        end
        else if (i_addr == `IPC_ADDR_ENABLE0 || i_addr == `IPC_ADDR_ENABLE1)
        begin
            rd_mux = st_ff.enable[i_addr[0]];
        end
        else if (i_addr >= `IPC_ADDR_PRIO0 && i_addr <= `IPC_ADDR_PRIO7)
        begin
            rd_mux = st_ff.prio[i_addr[2:0]];
        end
        else
        begin
            case (i_addr)
                `IPC_ADDR_CTRL1:      rd_mux = st_ff.ctrl1;
                `IPC_ADDR_CTRL2:      rd_mux = st_ff.ctrl2;
                `IPC_ADDR_PENDING:    rd_mux = {1'b0, st_ff.pending_level_field, 4'h0, st_ff.vector_number_field};
                `IPC_ADDR_ALU_STATUS: rd_mux = {8'h00, st_ff.cpu_level_low, 5'h00};
                `IPC_ADDR_CORE_CTRL:  rd_mux = {12'h000, st_ff.cpu_level_top_bit, 3'h0};
                `IPC_ADDR_EV_STATUS:  rd_mux = {13'h0000, st_ff.ev_status};
                `IPC_ADDR_EV_ENABLE:  rd_mux = {13'h0000, st_ff.ev_enable};
                default:              rd_mux = 16'h0000;
            endcase
        end
        // Flag register five is read from the live copy so the wake bit is visible.
        if (i_addr == `IPC_ADDR_FLAG5)
        begin
            rd_mux = st_ff.flag[5];
        end
    end

    always_comb
    begin
        nxt_st = st_ff;
        clr_mask = 16'h0000;
        ev_set = 3'h0;
        nxt_st.rdata = i_rd ? rd_mux : 16'h0000;

        if (i_wr)
        begin
            if (i_addr >= `IPC_ADDR_FLAG0 && i_addr <= `IPC_ADDR_FLAG5)
            begin
                nxt_st.flag[i_addr[2:0]] = i_wdata;
            end
            else if (i_addr == `IPC_ADDR_ENABLE0)
            begin
                nxt_st.enable[0] = i_wdata;
            end
            else if (i_addr == `IPC_ADDR_ENABLE1)
            begin
                nxt_st.enable[1] = i_wdata & `IPC_ENABLE1_MASK;
            end
            else if (i_addr >= `IPC_ADDR_PRIO0 && i_addr <= `IPC_ADDR_PRIO7)
            begin
                nxt_st.prio[i_addr[2:0]] = i_wdata & 16'h7777;
            end
            else
            begin
                case (i_addr)
                    `IPC_ADDR_CTRL1:      nxt_st.ctrl1 = i_wdata;
                    `IPC_ADDR_CTRL2:      nxt_st.ctrl2 = i_wdata;
                    `IPC_ADDR_ALU_STATUS: nxt_st.cpu_level_low = i_wdata[`IPC_LEVEL_LSB +: 3];
                    `IPC_ADDR_EV_CLEAR:   clr_mask = i_wdata;
                    `IPC_ADDR_EV_ENABLE:  nxt_st.ev_enable = i_wdata[2:0];
                    default:              nxt_st.ctrl1 = nxt_st.ctrl1;
                endcase
            end
        end

        // Hardware sets win over a software write in the same cycle.
        for (int s = 0; s < `IPC_NUM_SRC; s++)
        begin
            if (i_src_req[s])
            begin
                nxt_st.flag[s/16][s%16] = 1'b1;
            end
        end
        // Trap status flags live in the low bits of control one.
        if (i_trap_set)
        begin
            nxt_st.ctrl1[1] = 1'b1;
        end
        // Top level bit changes only by core trap entry and exit.
        if (i_cpu_level_top_set)
        begin
            nxt_st.cpu_level_top_bit = 1'b1;
        end
        else if (i_cpu_level_top_clr)
        begin
            nxt_st.cpu_level_top_bit = 1'b0;
        end

        if (best_any)
        begin
            nxt_st.vector_number_field = best_vec;
            nxt_st.pending_level_field = {1'b0, best_prio};
        end
        nxt_st.cpu_irq = best_any && ({1'b0, best_prio} > cpu_level) && !i_irq_ack;
        if (i_irq_ack && best_any)
        begin
            nxt_st.cpu_level_low = best_prio;
        end

        nxt_st.use_alt_table = st_ff.ctrl2[`IPC_ALT_TABLE_BIT];
        nxt_st.wake = 1'b0;
        case (st_ff.pwr)
            ipc_pkg::PWR_RUN:
            begin
                if (i_power_save_instruction)
                begin
                    nxt_st.pwr = ipc_pkg::PWR_ENTER;
                    nxt_st.deferred = any_enabled;
                end
            end
            ipc_pkg::PWR_ENTER:
            begin
                // Arrivals during entry are held until the mode is reached.
                nxt_st.deferred = st_ff.deferred | any_enabled;
                nxt_st.pwr = i_power_save_sleep ? ipc_pkg::PWR_SLEEP : ipc_pkg::PWR_IDLE;
            end
            ipc_pkg::PWR_IDLE:
            begin
                if (st_ff.deferred || any_enabled)
                begin
                    nxt_st.wake = 1'b1;
                    nxt_st.deferred = 1'b0;
                    nxt_st.pwr = ipc_pkg::PWR_RUN;
                    ev_set[0] = 1'b1;
                end
            end
            ipc_pkg::PWR_SLEEP:
            begin
                if (st_ff.deferred || any_enabled || i_low_power_wake_detector)
                begin
                    nxt_st.wake = 1'b1;
                    nxt_st.deferred = 1'b0;
                    nxt_st.pwr = ipc_pkg::PWR_RUN;
                    ev_set[1] = 1'b1;
                    if (i_low_power_wake_detector)
                    begin
                        nxt_st.flag[5][0] = 1'b1;
                    end
                end
            end
            default: nxt_st.pwr = ipc_pkg::PWR_RUN;
        endcase
        ev_set[2] = nxt_st.cpu_irq & ~st_ff.cpu_irq;

        nxt_st.ev_status = (st_ff.ev_status & ~clr_mask[2:0]) | ev_set;
        nxt_st.irq = |(nxt_st.ev_status & nxt_st.ev_enable);
        nxt_st.pc_reset = `IPC_RESET_VECTOR;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            st_ff <= '0;
        end
        else if (i_clk_en)
        begin
            st_ff <= nxt_st;
        end
    end

    // The table holds 126 entries; the vector field only carries source numbers 0 to 31 of them.
    assign o_rdata           = st_ff.rdata;
    assign o_cpu_irq         = st_ff.cpu_irq;
    assign o_vector_number   = st_ff.vector_number_field;
    assign o_pending_level   = st_ff.pending_level_field;
    assign o_use_alt_table   = st_ff.use_alt_table;
    assign o_nesting_disable = st_ff.ctrl1[`IPC_NEST_DIS_BIT];
    assign o_wake            = st_ff.wake;
    assign o_reset_pc        = st_ff.pc_reset;
    assign o_irq             = st_ff.irq;
endmodule // ipc_controller

// *** sim/ipc_monitor.sv ***
// Port-level assertions for the interrupt priority controller.
module ipc_monitor (
    input wire logic        i_ref_clk,
    input wire logic        i_rstn,
    input wire logic        i_clk_en,
    input wire logic [7:0]  i_addr,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] i_wdata,
    input wire logic [15:0] o_rdata,
    input wire logic        o_cpu_irq,
    input wire logic [3:0]  o_pending_level,
    input wire logic        o_use_alt_table,
    input wire logic        o_nesting_disable,
    input wire logic        o_wake,
    input wire logic [23:0] o_reset_pc,
    input wire logic        o_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    reset_quiet_a: assert property (
        disable iff (1'b0) !i_rstn && i_clk_en |=> !o_cpu_irq && !o_wake && !o_irq && o_rdata == 16'h0000)
        else $error("outputs not cleared by reset");
    reset_pc_a: assert property (
        o_reset_pc == 24'h00_0000) else $error("reset program counter not zero");
    rdata_idle_a: assert property (
        i_clk_en && !i_rd |=> o_rdata == 16'h0000) else $error("read data without read");
    enable_one_mask_a: assert property (
        i_clk_en && i_rd && i_addr == 8'h09 |=> (o_rdata & 16'h07A0) == 16'h0000)
        else $error("unimplemented enable bit reads one");
    status_level_a: assert property (
        i_clk_en && i_rd && i_addr == 8'h23 |=> (o_rdata & 16'hFF1F) == 16'h0000)
        else $error("status read outside level bits");
    nest_follow_a: assert property (
        i_clk_en && i_wr && i_addr == 8'h20 |=> o_nesting_disable == $past(i_wdata[15]))
        else $error("nesting disable not written");
    alt_follow_a: assert property (
        i_clk_en && i_wr && i_addr == 8'h21 |-> ##2 o_use_alt_table == $past(i_wdata[15], 2))
        else $error("alternate table select not followed");
    irq_level_a: assert property (
        o_cpu_irq |-> o_pending_level != 4'h0) else $error("request at level zero");
    wake_pulse_a: assert property (
        o_wake && i_clk_en |=> !o_wake) else $error("wake longer than one cycle");
endmodule // ipc_monitor

// *** sim/ipc_cpu_model.sv ***
// Core model that takes a raised interrupt after a set number of cycles.
module ipc_cpu_model #(
    parameter int DLY = 3
) (
    input  wire logic i_ref_clk,
    input  wire logic i_rstn,
    input  wire logic i_cpu_irq,
    output logic      o_irq_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt_ff;
    always @(posedge i_ref_clk)
    begin
        o_irq_ack <= 1'b0;
        if (!i_rstn || !i_cpu_irq)
            cnt_ff <= 0;
        else if (cnt_ff == DLY)
        begin
            o_irq_ack <= 1'b1;
            cnt_ff    <= 0;
        end
        else
            cnt_ff <= cnt_ff + 1;
    end
endmodule // ipc_cpu_model

// *** sim/ipc_controller_tb_top.sv ***
// Self-checking bench for the interrupt priority controller.
module ipc_controller_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rstn, psi, slp, ulp, trap, tset, tclr, ack, wr, rd, cen;
    logic        cirq, alt, nest, wake, irq;
    logic [31:0] req;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata;
    logic [6:0]  vec;
    logic [3:0]  lvl;
    logic [23:0] rpc;
    int          error_cnt = 0;
    int          checked = 0;
    int          cyc = 0;
    ipc_controller i_dut (.i_ref_clk(clk), .i_rstn(rstn), .i_clk_en(cen), .i_src_req(req),
        .i_low_power_wake_detector(ulp), .i_power_save_instruction(psi), .i_power_save_sleep(slp),
        .i_trap_set(trap), .i_cpu_level_top_set(tset), .i_cpu_level_top_clr(tclr), .i_irq_ack(ack),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_cpu_irq(cirq),
        .o_vector_number(vec), .o_pending_level(lvl), .o_use_alt_table(alt),
        .o_nesting_disable(nest), .o_wake(wake), .o_reset_pc(rpc), .o_irq(irq));
    ipc_cpu_model #(.DLY(3)) i_cpu (.i_ref_clk(clk), .i_rstn(rstn), .i_cpu_irq(cirq), .o_irq_ack(ack));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // One-cycle pulse: 0 top set, 1 top clear, 2 trap, 3 power-save instruction.
    task automatic pulse(input int sel);
        @(posedge clk);
        case (sel)
            0:       tset <= 1'b1;
            1:       tclr <= 1'b1;
            2:       trap <= 1'b1;
            default: psi  <= 1'b1;
        endcase
        @(posedge clk);
        {tset, tclr, trap, psi} <= 4'h0;
    endtask
    task automatic wait_wake;
        int n;
        n = 0;
        while (wake !== 1'h1 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        chk(wake, 1'h1);
    endtask
    task automatic finish_test;
        if (error_cnt == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // A hung wait ends the run as a failure.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            error_cnt++;
            finish_test();
        end
    end
    initial
    begin
        {rstn, psi, slp, ulp, trap, tset, tclr, wr, rd} = '0;
        cen = 1'b1;
        req = '0;
        addr = '0;
        wdata = '0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(8'h09, 16'h0000);
        chk(rpc, 24'h00_0000);
        wr_reg(8'h09, 16'hFFFF);
        rd_reg(8'h09, 16'hF85F);
        rd_reg(8'h3F, 16'h0000);
        wr_reg(8'h23, 16'hFFFF);
        rd_reg(8'h23, 16'h00E0);
        wr_reg(8'h24, 16'hFFFF);
        rd_reg(8'h24, 16'h0000);
        pulse(0);
        rd_reg(8'h24, 16'h0008);
        pulse(1);
        wr_reg(8'h23, 16'h0000);
        wr_reg(8'h10, 16'h0755);
        wr_reg(8'h08, 16'h0003);
        @(posedge clk);
        req <= 32'h0000_0007;
        @(posedge clk);
        req <= '0;
        @(posedge clk);
        #1 chk(vec, 7'h00);
        chk(lvl, 4'h5);
        chk(cirq, 1'h1);
        rd_reg(8'h00, 16'h0007);
        repeat (8) @(posedge clk);
        chk(cirq, 1'h0);
        rd_reg(8'h23, 16'h00A0);
        // A write while the clock enable is low must leave the level untouched.
        cen <= 1'b0;
        wr_reg(8'h23, 16'h0000);
        cen <= 1'b1;
        rd_reg(8'h23, 16'h00A0);
        wr_reg(8'h00, 16'h0000);
        rd_reg(8'h00, 16'h0000);
        wr_reg(8'h21, 16'h8000);
        repeat (2) @(posedge clk);
        chk(alt, 1'h1);
        wr_reg(8'h20, 16'h8000);
        #1 chk(nest, 1'h1);
        pulse(2);
        rd_reg(8'h20, 16'h8002);
        wr_reg(8'h29, 16'h0007);
        wr_reg(8'h2A, 16'h0007);
        @(posedge clk);
        psi    <= 1'b1;
        req[0] <= 1'b1;
        @(posedge clk);
        psi    <= 1'b0;
        req[0] <= 1'b0;
        wait_wake();
        rd_reg(8'h28, 16'h0001);
        chk(irq, 1'h1);
        wr_reg(8'h29, 16'h0001);
        wr_reg(8'h00, 16'h0000);
        wr_reg(8'h2A, 16'h0000);
        @(posedge clk);
        slp <= 1'b1;
        pulse(3);
        repeat (3) @(posedge clk);
        ulp <= 1'b1;
        wait_wake();
        ulp <= 1'b0;
        rd_reg(8'h05, 16'h0001);
        chk(irq, 1'h0);
        wr_reg(8'h2A, 16'h0002);
        repeat (2) @(posedge clk);
        chk(irq, 1'h1);
        wr_reg(8'h29, 16'h0002);
        repeat (2) @(posedge clk);
        chk(irq, 1'h0);
        finish_test();
    end
endmodule // ipc_controller_tb_top
bind ipc_controller ipc_monitor i_mon (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_clk_en(i_clk_en),
    .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .o_cpu_irq(o_cpu_irq), .o_pending_level(o_pending_level), .o_use_alt_table(o_use_alt_table),
    .o_nesting_disable(o_nesting_disable), .o_wake(o_wake), .o_reset_pc(o_reset_pc), .o_irq(o_irq));
